// ---- rtl/mtc_pkg.sv ----
// ********
// Shared constants of the five-channel timer
// ********
package mtc_pkg;

    // Channel geometry.
    localparam int NUM_CH = 5;
    localparam int NUM_GR = 2;
    localparam int CNT_W = 16;
    localparam int DIV_W = 6;

    // Reset values and the counter maximum.
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] GR_RESET = 16'hffff;
    localparam logic [5:0] DIV_RESET = 6'h00;
    localparam logic PIN_RESET = 1'b0;

    // Clock prescale selections; code 7 on channel 1 means cascade.
    localparam logic [2:0] PS_DIV1 = 3'h0;
    localparam logic [2:0] PS_DIV4 = 3'h1;
    localparam logic [2:0] PS_DIV16 = 3'h2;
    localparam logic [2:0] PS_DIV64 = 3'h3;
    localparam logic [2:0] PS_CASCADE = 3'h7;

    // Edge selections for count clocks and capture pins.
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    // Counter clear sources.
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_GRA = 2'h1;
    localparam logic [1:0] CLR_GRB = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;

    // Compare-match pin actions.
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // Capture trigger sources (alternatives only on channels 0 and 1).
    localparam logic [1:0] CAPSRC_PIN = 2'h0;
    localparam logic [1:0] CAPSRC_CLK = 2'h1;
    localparam logic [1:0] CAPSRC_MATCH = 2'h2;

endpackage : mtc_pkg

// ---- rtl/edge_detector.sv ----
`timescale 1ns/1ps
// ********
// Registered edge detector for synchronous inputs
// ********
module edge_detector
    import mtc_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Sampled levels.
    input wire logic [WIDTH-1:0] level,
    // Edge pulses, one cycle each.
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    // The only state is the previous level of each input.
    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } edge_state_t;

    edge_state_t cur; // Registered state.
    edge_state_t next_cur; // Next state.

    // Next state is simply the present level.
    always_comb
    begin
        next_cur = cur;
        next_cur.prev = level;
    end

    // State register; a high input right after reset reads as a rise.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // Edges compare the present level with the stored one.
    assign rise = level & ~cur.prev;
    assign fall = ~level & cur.prev;

endmodule : edge_detector

// ---- rtl/timer_unit.sv ----
`timescale 1ns/1ps
module timer_unit
    import mtc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Start and synchronisation control.
    input wire logic [NUM_CH-1:0] channel_run_bit,
    input wire logic [NUM_CH-1:0] sync_select,
    // Per-channel count control.
    input wire logic [NUM_CH-1:0][2:0] clock_prescale_select,
    input wire logic [NUM_CH-1:0][1:0] clock_edge_select,
    input wire logic [NUM_CH-1:0][1:0] clear_source_select,
    input wire logic [NUM_CH-1:0] phase_mode,
    input wire logic [NUM_CH-1:0] pwm_mode,
    // Per general register function control.
    input wire logic [NUM_CH-1:0][NUM_GR-1:0] gr_is_capture,
    input wire logic [NUM_CH-1:0][NUM_GR-1:0] out_initial,
    input wire logic [NUM_CH-1:0][NUM_GR-1:0][1:0] out_action,
    input wire logic [NUM_CH-1:0][NUM_GR-1:0][1:0] capture_edge,
    input wire logic [NUM_CH-1:0][NUM_GR-1:0][1:0] capture_source,
    input wire logic [NUM_CH-1:0][NUM_GR-1:0] buffer_enable,
    // Interrupt enables.
    input wire logic [NUM_CH-1:0] overflow_irq_enable,
    input wire logic [NUM_CH-1:0][NUM_GR-1:0] match_irq_enable,
    // Software writes; index 0,1 are general registers, 2,3 buffers.
    input wire logic [NUM_CH-1:0] cnt_write,
    input wire logic [NUM_CH-1:0][3:0] gr_write,
    input wire logic [15:0] write_data,
    // Flag clears, one-cycle pulses.
    input wire logic [NUM_CH-1:0] overflow_clear,
    input wire logic [NUM_CH-1:0][NUM_GR-1:0] match_clear,
    // External count clocks and capture pin levels.
    input wire logic [3:0] external_count_clock,
    input wire logic [NUM_CH-1:0][NUM_GR-1:0] capture_compare_pin_in,
    // Compare outputs.
    output logic [NUM_CH-1:0][NUM_GR-1:0] capture_compare_pin_out,
    output logic [NUM_CH-1:0][NUM_GR-1:0] capture_compare_pin_oe,
    // Counter, register and flag state.
    output logic [NUM_CH-1:0][15:0] channel_counter,
    output logic [NUM_CH-1:0][NUM_GR-1:0][15:0] general_compare_capture_reg,
    output logic [NUM_CH-1:0][NUM_GR-1:0][15:0] buffer_reg,
    output logic [NUM_CH-1:0] overflow_flag,
    output logic [NUM_CH-1:0][NUM_GR-1:0] match_capture_flag,
    // Interrupt requests, levels.
    output logic [NUM_CH-1:0] overflow_irq,
    output logic [NUM_CH-1:0][NUM_GR-1:0] match_irq
);

    // ********
    // State
    // ********

    // Every flip-flop of the unit outside the two edge detector banks lives in this one record.
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [NUM_CH-1:0][15:0] cnt;
        logic [NUM_CH-1:0][NUM_GR-1:0][15:0] gr;
        logic [NUM_CH-1:0][NUM_GR-1:0][15:0] buff;
        logic [NUM_CH-1:0] ovf;
        logic [NUM_CH-1:0][NUM_GR-1:0] flag;
        logic [NUM_CH-1:0][NUM_GR-1:0] pin;
    } timer_state_t;

    timer_state_t cur; // Registered state.
    timer_state_t next_cur; // Next state.

    logic [3:0] ext_rise; // External clock rising edges.
    logic [3:0] ext_fall; // External clock falling edges.
    logic [NUM_CH*NUM_GR-1:0] pin_rise; // Capture pin rising edges.
    logic [NUM_CH*NUM_GR-1:0] pin_fall; // Capture pin falling edges.
    logic [NUM_CH-1:0] up; // Count-up step this cycle.
    logic [NUM_CH-1:0] dn; // Count-down step this cycle.
    logic [NUM_CH-1:0][NUM_GR-1:0] match; // Compare matches.
    logic [NUM_CH-1:0][NUM_GR-1:0] cap; // Capture events.
    logic [NUM_CH-1:0] clr_evt; // Own clear events.
    logic sync_clr_any; // Clear event on any synced channel.
    logic sync_wr_any; // Write to any synced counter.

    // ********
    // Edge detection
    // ********

    // One detector bank for the external clocks.
    edge_detector #(.WIDTH(4)) u_ext_edges (
        .mclk(mclk),
        .rst_n(rst_n),
        .level(external_count_clock),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    // A second bank for the capture pins.
    edge_detector #(.WIDTH(NUM_CH*NUM_GR)) u_pin_edges (
        .mclk(mclk),
        .rst_n(rst_n),
        .level(capture_compare_pin_in),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // ********
    // Helpers
    // ********

    // Picks an edge of a signal by an edge selection code.
    function automatic logic pick_edge(input logic [1:0] sel, input logic r, input logic f);
        logic hit;
        hit = r | f;
        if (sel == EDGE_RISE)
        begin
            hit = r;
        end
        else if (sel == EDGE_FALL)
        begin
            hit = f;
        end
        return hit;
    endfunction : pick_edge

    // New pin level after a compare action; equal levels stay put.
    function automatic logic apply_act(input logic [1:0] act, input logic lvl);
        logic res;
        unique case (act)
            ACT_NONE: res = lvl;
            ACT_LOW: res = 1'b0;
            ACT_HIGH: res = 1'b1;
            ACT_TOGGLE: res = ~lvl;
        endcase
        return res;
    endfunction : apply_act

    // ********
    // Count steps
    // ********

    // Decides per channel whether the counter steps up or down now.
    // Internal rates come from one shared divider, so channels with
    // the same rate tick in the same cycle.
    always_comb
    begin
        up = '0;
        dn = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            // Prescale choice and its edge.
            unique case (clock_prescale_select[i])
                PS_DIV1: up[i] = 1'b1;
                PS_DIV4: up[i] = &cur.div[1:0];
                PS_DIV16: up[i] = &cur.div[3:0];
                PS_DIV64: up[i] = &cur.div;
                default: up[i] = pick_edge(clock_edge_select[i],
                    ext_rise[clock_prescale_select[i][1:0]],
                    ext_fall[clock_prescale_select[i][1:0]]);
            endcase
            up[i] = up[i] & channel_run_bit[i];
        end
        // Quadrature decode: channel 1 uses clocks 0,1, channel 2 uses 2,3.
        for (int i = 1; i < 3; i++)
        begin
            if (phase_mode[i])
            begin
                up[i] = channel_run_bit[i] &&
                    (((ext_rise[2*i-2] | ext_fall[2*i-2]) &&
                      (external_count_clock[2*i-2] != external_count_clock[2*i-1])) ||
                     ((ext_rise[2*i-1] | ext_fall[2*i-1]) &&
                      (external_count_clock[2*i-2] == external_count_clock[2*i-1])));
                dn[i] = channel_run_bit[i] && !up[i] &&
                    (ext_rise[2*i-2] | ext_fall[2*i-2] | ext_rise[2*i-1] | ext_fall[2*i-1]);
            end
        end
        // Cascade: channel 1 holds the upper half and follows the wraps
        // of channel 2 in both directions.
        if (!phase_mode[1] && clock_prescale_select[1] == PS_CASCADE)
        begin
            up[1] = channel_run_bit[1] && up[2] && cur.cnt[2] == CNT_MAX;
            dn[1] = channel_run_bit[1] && dn[2] && cur.cnt[2] == CNT_RESET;
        end
    end

    // ********
    // Match, capture and clear events
    // ********

    // Matches are taken at the count step on the matched value, so a
    // period register of N gives N+1 counts per period.
    always_comb
    begin
        match = '0;
        cap = '0;
        clr_evt = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            for (int g = 0; g < NUM_GR; g++)
            begin
                match[i][g] = !gr_is_capture[i][g] && (up[i] | dn[i]) &&
                    cur.cnt[i] == cur.gr[i][g];
            end
        end
        for (int i = 0; i < NUM_CH; i++)
        begin
            for (int g = 0; g < NUM_GR; g++)
            begin
                cap[i][g] = pick_edge(capture_edge[i][g], pin_rise[i*NUM_GR+g],
                    pin_fall[i*NUM_GR+g]);
                // Channels 0 and 1 may listen to the next channel instead.
                if (i < 2 && capture_source[i][g] == CAPSRC_CLK)
                begin
                    cap[i][g] = up[i+1] | dn[i+1];
                end
                else if (i < 2 && capture_source[i][g] == CAPSRC_MATCH)
                begin
                    cap[i][g] = match[i+1][0];
                end
                cap[i][g] = cap[i][g] & gr_is_capture[i][g];
            end
            clr_evt[i] = (clear_source_select[i] == CLR_GRA && (match[i][0] | cap[i][0])) ||
                (clear_source_select[i] == CLR_GRB && (match[i][1] | cap[i][1]));
        end
        sync_clr_any = |(clr_evt & sync_select);
        sync_wr_any = |(cnt_write & sync_select);
    end

    // ********
    // Next state
    // ********

    // Updates counters, registers, flags and pins. Hardware events on the
    // general and buffer registers are applied after software writes so a capture is never lost.
    always_comb
    begin
        next_cur = cur;
        next_cur.div = cur.div + 6'h01;
        for (int i = 0; i < NUM_CH; i++)
        begin
            // Counter step; wrap to zero keeps counting.
            if (up[i])
            begin
                next_cur.cnt[i] = cur.cnt[i] + 16'h0001;
            end
            else if (dn[i])
            begin
                next_cur.cnt[i] = cur.cnt[i] - 16'h0001;
            end
            // Own clear or clear shared among synced channels.
            if (clr_evt[i] || (clear_source_select[i] == CLR_SYNC && sync_select[i] && sync_clr_any))
            begin
                next_cur.cnt[i] = CNT_RESET;
            end
            // A software write presets this counter, and every synced counter if this one is synced.
            if (cnt_write[i] || (sync_select[i] && sync_wr_any))
            begin
                next_cur.cnt[i] = write_data;
            end
            // Overflow flag; a wrap in the clearing cycle wins.
            if (overflow_clear[i])
            begin
                next_cur.ovf[i] = 1'b0;
            end
            if (up[i] && cur.cnt[i] == CNT_MAX)
            begin
                next_cur.ovf[i] = 1'b1;
            end
            for (int g = 0; g < NUM_GR; g++)
            begin
                // Software writes to general and buffer registers.
                if (gr_write[i][g])
                begin
                    next_cur.gr[i][g] = write_data;
                end
                if (gr_write[i][g+2])
                begin
                    next_cur.buff[i][g] = write_data;
                end
                // Buffered compare reloads the general register.
                if (match[i][g] && buffer_enable[i][g])
                begin
                    next_cur.gr[i][g] = cur.buff[i][g];
                end
                // Capture stores the counter, shifting the old value out.
                if (cap[i][g])
                begin
                    next_cur.gr[i][g] = cur.cnt[i];
                    if (buffer_enable[i][g])
                    begin
                        next_cur.buff[i][g] = cur.gr[i][g];
                    end
                end
                // Match or capture flag; set beats a same-cycle clear.
                if (match_clear[i][g])
                begin
                    next_cur.flag[i][g] = 1'b0;
                end
                if (match[i][g] || cap[i][g])
                begin
                    next_cur.flag[i][g] = 1'b1;
                end
            end
            // Pin levels: initial level while stopped, actions while running.
            if (!channel_run_bit[i])
            begin
                next_cur.pin[i] = out_initial[i];
            end
            else if (pwm_mode[i])
            begin
                // Both registers steer one pin; equal values mean no
                // change, which gives the 0% and 100% duty ends.
                if (match[i][0] && !match[i][1])
                begin
                    next_cur.pin[i][0] = apply_act(out_action[i][0], cur.pin[i][0]);
                end
                else if (match[i][1] && !match[i][0])
                begin
                    next_cur.pin[i][0] = apply_act(out_action[i][1], cur.pin[i][0]);
                end
            end
            else
            begin
                for (int g = 0; g < NUM_GR; g++)
                begin
                    if (match[i][g])
                    begin
                        next_cur.pin[i][g] = apply_act(out_action[i][g], cur.pin[i][g]);
                    end
                end
            end
        end
    end

    // ********
    // State register
    // ********

    // Reset leaves every counter at zero with no clear source chosen
    // by this block, i.e. free-running once started.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur.div <= DIV_RESET;
            cur.cnt <= {NUM_CH{CNT_RESET}};
            cur.gr <= {(NUM_CH*NUM_GR){GR_RESET}};
            cur.buff <= {(NUM_CH*NUM_GR){GR_RESET}};
            cur.ovf <= '0;
            cur.flag <= '0;
            cur.pin <= {(NUM_CH*NUM_GR){PIN_RESET}};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ********
    // Outputs
    // ********

    // The pin drives only for compare use; in PWM the second pin idles.
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            for (int g = 0; g < NUM_GR; g++)
            begin
                capture_compare_pin_oe[i][g] = !gr_is_capture[i][g] && !(pwm_mode[i] && g == 1);
            end
        end
    end

    assign capture_compare_pin_out = cur.pin;
    assign channel_counter = cur.cnt;
    assign general_compare_capture_reg = cur.gr;
    assign buffer_reg = cur.buff;
    assign overflow_flag = cur.ovf;
    assign match_capture_flag = cur.flag;
    // Interrupt requests follow the flags while enabled.
    assign overflow_irq = cur.ovf & overflow_irq_enable;
    assign match_irq = cur.flag & match_irq_enable;

endmodule : timer_unit

// ---- verif/timer_unit_asserts.sv ----
`timescale 1ns/1ps
// ********
// Port checker for the timer unit, channel 0 to 2 behaviour
// ********
module timer_unit_asserts
    import mtc_pkg::*;
(
    // Clock and reset.
    input logic mclk,
    input logic rst_n,
    // Controls.
    input logic [NUM_CH-1:0] channel_run_bit,
    input logic [NUM_CH-1:0] sync_select,
    input logic [NUM_CH-1:0][2:0] clock_prescale_select,
    input logic [NUM_CH-1:0][1:0] clear_source_select,
    input logic [NUM_CH-1:0][NUM_GR-1:0] gr_is_capture,
    input logic [NUM_CH-1:0][NUM_GR-1:0] out_initial,
    input logic [NUM_CH-1:0][NUM_GR-1:0][1:0] out_action,
    input logic [NUM_CH-1:0] overflow_irq_enable,
    input logic [NUM_CH-1:0][NUM_GR-1:0] match_irq_enable,
    input logic [NUM_CH-1:0] cnt_write,
    input logic [15:0] write_data,
    // Observed state.
    input logic [NUM_CH-1:0][NUM_GR-1:0] capture_compare_pin_out,
    input logic [NUM_CH-1:0][15:0] channel_counter,
    input logic [NUM_CH-1:0][NUM_GR-1:0][15:0] general_compare_capture_reg,
    input logic [NUM_CH-1:0] overflow_flag,
    input logic [NUM_CH-1:0][NUM_GR-1:0] match_capture_flag,
    input logic [NUM_CH-1:0] overflow_irq,
    input logic [NUM_CH-1:0][NUM_GR-1:0] match_irq
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Channel 0 steps every cycle and no write can override the step.
    wire logic plain_step = channel_run_bit[0] && clock_prescale_select[0] == PS_DIV1 && cnt_write == '0;
    wire logic free_run = plain_step && clear_source_select[0] == CLR_NONE;
    // A compare match of register A on channel 0 in the current cycle.
    wire logic hit_a = plain_step && !gr_is_capture[0][0] && channel_counter[0] == general_compare_capture_reg[0][0];
    run_gate_a: assert property (!channel_run_bit[0] && cnt_write == '0 && clear_source_select[0] == CLR_NONE
        |=> $stable(channel_counter[0])) else $error("stopped counter moved");
    step_one_a: assert property (free_run && channel_counter[0] != CNT_MAX
        |=> channel_counter[0] == $past(channel_counter[0]) + 16'h0001) else $error("counter step wrong");
    wrap_a: assert property (free_run && channel_counter[0] == CNT_MAX
        |=> overflow_flag[0] && channel_counter[0] == CNT_RESET) else $error("wrap not flagged");
    ovf_irq_a: assert property ($rose(overflow_flag[0]) && overflow_irq_enable[0] |-> overflow_irq[0])
        else $error("overflow request missing");
    match_irq_a: assert property ($rose(match_capture_flag[0][0]) && match_irq_enable[0][0] |-> match_irq[0][0])
        else $error("match request missing");
    period_clear_a: assert property (hit_a && clear_source_select[0] == CLR_GRA
        |=> channel_counter[0] == CNT_RESET && match_capture_flag[0][0]) else $error("period clear wrong");
    pin_initial_a: assert property (!channel_run_bit[0]
        |=> capture_compare_pin_out[0][0] == $past(out_initial[0][0])) else $error("pin left initial level");
    pin_toggle_a: assert property (hit_a && out_action[0][0] == ACT_TOGGLE
        |=> capture_compare_pin_out[0][0] != $past(capture_compare_pin_out[0][0])) else $error("pin did not toggle");
    sync_preset_a: assert property (cnt_write[1] && sync_select[1] && sync_select[2]
        |=> channel_counter[2] == $past(write_data)) else $error("synced preset missing");
endmodule : timer_unit_asserts

bind timer_unit timer_unit_asserts u_asserts (.*);

// ---- verif/count_clock_model.sv ----
`timescale 1ns/1ps
// ********
// External count clock source beyond the timer pins
// ********
module count_clock_model
(
    // Clock and reset.
    input logic mclk,
    input logic rst_n,
    // Source gate.
    input logic enable,
    // Clock lines.
    output logic [3:0] external_count_clock
);
    logic [1:0] phase; // Cycles since the last transition.
    // Line 0 flips every fourth cycle; a stopped source freezes its level.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase <= 2'h0;
            external_count_clock <= 4'h0;
        end
        else if (enable)
        begin
            phase <= phase + 2'h1;
            if (phase == 2'h3)
                external_count_clock[0] <= !external_count_clock[0];
        end
    end
endmodule : count_clock_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
// ********
// Self-checking bench for the timer unit
// ********
module testbench
    import mtc_pkg::*;
();
    logic mclk, rst_n, ext_en;
    logic [NUM_CH-1:0] channel_run_bit, sync_select, phase_mode, pwm_mode, overflow_irq_enable;
    logic [NUM_CH-1:0] cnt_write, overflow_clear, overflow_flag, overflow_irq;
    logic [NUM_CH-1:0][2:0] clock_prescale_select;
    logic [NUM_CH-1:0][1:0] clock_edge_select, clear_source_select;
    logic [NUM_CH-1:0][NUM_GR-1:0] gr_is_capture, out_initial, buffer_enable, match_irq_enable, match_clear;
    logic [NUM_CH-1:0][NUM_GR-1:0] capture_compare_pin_in, capture_compare_pin_out, capture_compare_pin_oe;
    logic [NUM_CH-1:0][NUM_GR-1:0] match_capture_flag, match_irq;
    logic [NUM_CH-1:0][NUM_GR-1:0][1:0] out_action, capture_edge, capture_source;
    logic [NUM_CH-1:0][3:0] gr_write;
    logic [3:0] external_count_clock;
    logic [15:0] write_data, base, exp_gr, exp_buf;
    logic [NUM_CH-1:0][15:0] channel_counter;
    logic [NUM_CH-1:0][NUM_GR-1:0][15:0] general_compare_capture_reg, buffer_reg;
    int n_fail, checked;
`define CHECK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
        end \
    end
    timer_unit DUT (.*);
    count_clock_model u_far_side (.mclk, .rst_n, .enable(ext_en), .external_count_clock);
    // Free-running 100 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = !mclk;
    end
    // Waits n edges, then lets outputs settle.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    // Write pulse; sel 4 is the counter.
    task automatic wr(input int ch, input int sel, input logic [15:0] v);
        @(posedge mclk);
        write_data <= v;
        if (sel == 4)
            cnt_write[ch] <= 1'b1;
        else
            gr_write[ch][sel] <= 1'b1;
        @(posedge mclk);
        cnt_write <= '0;
        gr_write <= '0;
        #1;
    endtask : wr
    // Single place where the verdict is printed.
    task automatic end_of_test();
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Tests take under 2000 cycles; a hang ends at 5000.
    initial
    begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end
    initial
    begin
        {channel_run_bit, sync_select, clock_prescale_select, clock_edge_select, clear_source_select, phase_mode,
         pwm_mode, gr_is_capture, out_initial, out_action, capture_edge, capture_source, buffer_enable,
         overflow_irq_enable, match_irq_enable, cnt_write, gr_write, write_data, overflow_clear, match_clear,
         capture_compare_pin_in} = '0;
        {rst_n, ext_en, n_fail, checked} = '0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        // Stopped channel keeps its count and shows the initial pin level.
        @(posedge mclk);
        out_initial[0][0] <= 1'b1;
        overflow_irq_enable[0] <= 1'b1;
        match_irq_enable[0][0] <= 1'b1;
        tick(4);
        `CHECK("stopped count", 16'h0000, channel_counter[0]);
        `CHECK("initial pin", 1'b1, capture_compare_pin_out[0][0]);
        // Free run through the wrap point.
        @(posedge mclk);
        channel_run_bit[0] <= 1'b1;
        wr(0, 4, 16'hfffe);
        tick(2);
        `CHECK("wrap count", 16'h0000, channel_counter[0]);
        `CHECK("overflow flag", 1'b1, overflow_flag[0]);
        `CHECK("overflow request", 1'b1, overflow_irq[0]);
        tick(3);
        `CHECK("after wrap", 16'h0003, channel_counter[0]);
        @(posedge mclk);
        overflow_irq_enable[0] <= 1'b0;
        tick(1);
        `CHECK("masked request", 1'b0, overflow_irq[0]);
        @(posedge mclk);
        overflow_clear[0] <= 1'b1;
        @(posedge mclk);
        overflow_clear[0] <= 1'b0;
        tick(1);
        `CHECK("flag cleared", 1'b0, overflow_flag[0]);
        // Every internal rate and every external edge choice over 64 cycles.
        for (int k = 0; k < 7; k++)
        begin
            @(posedge mclk);
            ext_en <= 1'b1;
            clock_prescale_select[0] <= (k < 4) ? 3'(k) : 3'h4;
            clock_edge_select[0] <= (k < 4) ? EDGE_RISE : 2'(k - 4);
            tick(3);
            base = channel_counter[0];
            tick(64);
            `CHECK("steps", (k < 4) ? 16'(64 >> (2 * k)) : (k == 6) ? 16'h0010 : 16'h0008, channel_counter[0] - base);
        end
        // Period of three cycles from register A, pin driven low, high, toggled.
        @(posedge mclk);
        clock_prescale_select[0] <= PS_DIV1;
        clear_source_select[0] <= CLR_GRA;
        out_action[0][0] <= ACT_LOW;
        match_clear[0][0] <= 1'b1;
        wr(0, 0, 16'h0002);
        match_clear <= '0;
        wr(0, 4, 16'h0000);
        `CHECK("pin before match", 1'b1, capture_compare_pin_out[0][0]);
        `CHECK("match flag idle", 1'b0, match_capture_flag[0][0]);
        `CHECK("pin drive", 1'b1, capture_compare_pin_oe[0][0]);
        tick(3);
        `CHECK("period clear", 16'h0000, channel_counter[0]);
        `CHECK("match flag", 1'b1, match_capture_flag[0][0]);
        `CHECK("match request", 1'b1, match_irq[0][0]);
        `CHECK("pin low", 1'b0, capture_compare_pin_out[0][0]);
        tick(3);
        `CHECK("pin kept", 1'b0, capture_compare_pin_out[0][0]);
        @(posedge mclk);
        out_action[0][0] <= ACT_HIGH;
        tick(3);
        `CHECK("pin high", 1'b1, capture_compare_pin_out[0][0]);
        @(posedge mclk);
        out_action[0][0] <= ACT_TOGGLE;
        tick(3);
        `CHECK("pin toggled", 1'b0, capture_compare_pin_out[0][0]);
        // Captures on channel 3 with buffering, stopped so the count is known.
        @(posedge mclk);
        gr_is_capture[3][0] <= 1'b1;
        buffer_enable[3][0] <= 1'b1;
        exp_gr = GR_RESET;
        exp_buf = GR_RESET;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge mclk);
            capture_edge[3][0] <= 2'(i / 2);
            wr(3, 4, 16'h0100 + 16'(i));
            @(posedge mclk);
            capture_compare_pin_in[3][0] <= (i % 2 == 0);
            tick(4);
            if (i / 2 == 2 || i % 2 == i / 2)
            begin
                exp_buf = exp_gr;
                exp_gr = 16'h0100 + 16'(i);
            end
            `CHECK("captured", exp_gr, general_compare_capture_reg[3][0]);
            `CHECK("buffered", exp_buf, buffer_reg[3][0]);
            `CHECK("capture pin idle", 1'b0, capture_compare_pin_oe[3][0]);
        end
        // Channels 1 and 2 synced: shared preset, then shared clear.
        @(posedge mclk);
        sync_select <= 5'h06;
        clear_source_select[1] <= CLR_GRA;
        clear_source_select[2] <= CLR_SYNC;
        wr(1, 0, 16'h123a);
        wr(1, 4, 16'h1234);
        `CHECK("synced preset", 16'h1234, channel_counter[2]);
        `CHECK("unsynced kept", 16'h0105, channel_counter[3]);
        @(posedge mclk);
        channel_run_bit[2:1] <= 2'h3;
        tick(10);
        `CHECK("clearing channel", 16'h0003, channel_counter[1]);
        `CHECK("synced clear", 16'h0003, channel_counter[2]);
        // Cascade: channel 1 counts channel 2 wraps.
        @(posedge mclk);
        sync_select <= '0;
        clear_source_select <= '0;
        clock_prescale_select[1] <= PS_CASCADE;
        wr(1, 4, 16'h0005);
        wr(2, 4, 16'hfffe);
        tick(2);
        `CHECK("upper half", 16'h0006, channel_counter[1]);
        end_of_test();
    end
endmodule : testbench
